// file: design/pmr_sequencer.sv
// Power-mode and reset sequencer with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Any reset ends in Active after configuration load.
// - Every reset source returns to Active.
// - Sleep halts CPU, gates core clock only.
// - Interrupt or wake event leaves Sleep.
// - Partial wake runs bus master, then sleeps.
// - Deep Sleep retains registers; SRAM per-block retention.
// - Core, GPIO or always-on events wake Deep Sleep.
// - Deep Power Down gates core and regulator.
// - Deep Power Down exits only through reset.
// - Power Down exits only through reset.
// - Wake reset for domains that were off.
// - Low external reset pin resets device.
// - Power-on reset resets every domain.
// - Reset acknowledge missing over 8192 ticks resets.
// - Missing low-power acknowledge over 8192 ticks resets.
// - Enabled clock loss or lock loss resets.
// - Low-voltage detector enabled by default, resets.
// - High-voltage detector disabled by default, resets.
// - Each watchdog expiry causes its own reset.
// - Software system-reset request resets device.
// - Processor lockup resets device.
// - Debug port or JTAG requests reset.
// - Security violation causes security reset.
module pmr_sequencer
	import pmr_pkg::*;
#(
	parameter int SRAM_BLOCKS = 8,
	parameter int TIMEOUT_LIMIT = TIMEOUT_TICKS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_reset_n,
	input wire logic switch_wake_n,
	input wire logic rtc_clk_32k,
	input wire pmr_rst_src_s rst_src,
	input wire pmr_wake_src_s wake_src,
	input wire logic lp_ack,
	input wire logic rst_ack,
	input wire logic cfg_done,
	output logic sys_reset_n,
	output logic wake_reset_n,
	output logic lp_req,
	output logic cfg_load,
	output logic switch_on,
	output logic switched_supply_out_en,
	output pmr_pwr_ctl_s pwr_ctl,
	output logic [SRAM_BLOCKS-1:0] sram_pwr_en,
	output logic [SRAM_BLOCKS-1:0] sram_retain
);

	// ========================================================================
	// Elaboration checks.
	if (SRAM_BLOCKS < 1 || SRAM_BLOCKS > 32) begin : g_bad_sram
		$error("SRAM_BLOCKS must lie between 1 and 32.");
	end
	if (TIMEOUT_LIMIT < 1 || TIMEOUT_LIMIT > 32767) begin : g_bad_timeout
		$error("TIMEOUT_LIMIT must lie between 1 and 32767.");
	end

	localparam logic [14:0] TICK_LIMIT = 15'(TIMEOUT_LIMIT);
	localparam logic [5:0] WAKE_CYC = 6'(SWITCH_WAKE_CYC);
	localparam logic [4:0] HOLD_CYC = 5'(RST_HOLD_CYC);

	// ========================================================================
	// All state of the block.
	typedef struct packed {
		pmr_state_e state;
		logic [2:0] lp_target;
		logic [CTRL_W-1:0] ctrl;
		logic [31:0] sram_cfg;
		pmr_cause_e cause;
		logic wake_rst;
		logic [4:0] hold_cnt;
		logic [14:0] ticks;
		logic a_valid;
		logic a_write;
		logic [7:0] a_addr;
		logic [31:0] rdata;
		logic [2:0] pin_s;
		logic pin_f;
		logic [2:0] wk_s;
		logic wk_f;
		logic [5:0] wk_cnt;
		logic [2:0] rtc_s;
		logic rtc_f;
		logic switch_on;
	} pmr_st_s;

	localparam pmr_st_s ST_RESET = '{
		state: ST_RST_HOLD,
		lp_target: 3'h0,
		ctrl: CTRL_RST,
		sram_cfg: SRAM_RST,
		cause: CAUSE_POR,
		wake_rst: 1'b1,
		hold_cnt: 5'h00,
		ticks: 15'h0000,
		a_valid: 1'b0,
		a_write: 1'b0,
		a_addr: 8'h00,
		rdata: 32'h00000000,
		pin_s: 3'h7,
		pin_f: 1'b1,
		wk_s: 3'h7,
		wk_f: 1'b1,
		wk_cnt: 6'h00,
		rtc_s: 3'h0,
		rtc_f: 1'b0,
		switch_on: 1'b1
	};

	pmr_st_s s;
	pmr_st_s next_s;
	logic rtc_tick;
	logic switch_wake;
	logic rst_req;
	pmr_cause_e rst_cause;
	logic powered_off;
	logic [31:0] rd_mux;
	logic [31:0] sram_mask;

	assign sram_mask = 32'((64'h1 << SRAM_BLOCKS) - 64'h1);
	assign powered_off = (s.state == ST_POWER_DOWN) || (s.state == ST_DEEP_POWER_DOWN);

	// Reset requests by fixed priority. While the core is off only always-on sources can act,
	// because the core-side sources are unpowered and would float.
	always_comb begin
		rst_req = 1'b1;
		rst_cause = CAUSE_NONE;
		if (!s.pin_f) begin
			rst_cause = CAUSE_PIN;
		end else if (s.ctrl[CTRL_LVD_EN] && rst_src.low_voltage_detector) begin
			rst_cause = CAUSE_LVD;
		end else if (s.ctrl[CTRL_HVD_EN] && rst_src.high_voltage_detector) begin
			rst_cause = CAUSE_HVD;
		end else if (s.state == ST_DEEP_POWER_DOWN && wake_src.always_on_system_domain) begin
			rst_cause = CAUSE_WAKEUP;
		end else if (s.state == ST_POWER_DOWN && switch_wake) begin
			rst_cause = CAUSE_WAKEUP;
		end else if (powered_off) begin
			rst_req = 1'b0;
		end else if (rst_src.security_violation_reset) begin
			rst_cause = CAUSE_SECURITY;
		end else if ((s.ctrl[CTRL_SCG_LOC_EN] && rst_src.clock_loss) ||
				(s.ctrl[CTRL_SCG_LOL_EN] && rst_src.lock_loss)) begin
			rst_cause = CAUSE_CLOCK_GEN;
		end else if (rst_src.watchdog_a) begin
			rst_cause = CAUSE_WATCHDOG_A;
		end else if (rst_src.watchdog_b) begin
			rst_cause = CAUSE_WATCHDOG_B;
		end else if (rst_src.lockup) begin
			rst_cause = CAUSE_LOCKUP;
		end else if (rst_src.debug_access_port) begin
			rst_cause = CAUSE_DEBUG_PORT;
		end else if (rst_src.jtag_req) begin
			rst_cause = CAUSE_JTAG;
		end else if (rst_src.software_req) begin
			rst_cause = CAUSE_SOFTWARE;
		end else begin
			rst_req = 1'b0;
		end
	end

	// Register read multiplexer; unmapped words read as zero.
	always_comb begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			OFS_CTRL: rd_mux = {26'h0000000, s.ctrl};
			OFS_SRAM: rd_mux = s.sram_cfg & sram_mask;
			OFS_MODE: rd_mux = {19'h00000, s.lp_target, s.state};
			OFS_CAUSE: rd_mux = {26'h0000000, s.wake_rst, s.cause};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Filtered pin and clock events; the first synchroniser stage only feeds the second.
	assign rtc_tick = (s.rtc_s[1] == s.rtc_s[2]) && s.rtc_s[2] && !s.rtc_f;
	assign switch_wake = !s.wk_f && (s.wk_cnt == WAKE_CYC - 6'h01);

	// ========================================================================
	// Next-state logic.
	always_comb begin
		next_s = s;

		// Three-stage sampling of the asynchronous inputs.
		next_s.pin_s = {s.pin_s[1:0], ext_reset_n};
		next_s.wk_s = {s.wk_s[1:0], switch_wake_n};
		next_s.rtc_s = {s.rtc_s[1:0], rtc_clk_32k};
		if (s.pin_s[1] == s.pin_s[2]) begin
			next_s.pin_f = s.pin_s[2];
		end
		if (s.wk_s[1] == s.wk_s[2]) begin
			next_s.wk_f = s.wk_s[2];
		end
		if (s.rtc_s[1] == s.rtc_s[2]) begin
			next_s.rtc_f = s.rtc_s[2];
		end

		// A short glitch on the wake pin must not turn the switch on, so the low time is counted.
		if (s.wk_f) begin
			next_s.wk_cnt = 6'h00;
		end else if (s.wk_cnt != WAKE_CYC) begin
			next_s.wk_cnt = s.wk_cnt + 6'h01;
		end
		if (switch_wake) begin
			next_s.switch_on = 1'b1;
		end

		// Bus slave: capture address phase, answer reads from a flip-flop in the data phase.
		next_s.a_valid = hsel && hready && htrans[1];
		next_s.a_write = hwrite;
		next_s.a_addr = haddr[7:0];
		if (hsel && hready && htrans[1] && !hwrite) begin
			next_s.rdata = rd_mux;
		end
		if (s.a_valid && s.a_write) begin
			case (s.a_addr)
				OFS_CTRL: next_s.ctrl = hwdata[CTRL_W-1:0];
				OFS_SRAM: next_s.sram_cfg = hwdata & sram_mask;
				OFS_CAUSE: next_s.cause = CAUSE_NONE;
				default: next_s.ctrl = s.ctrl;
			endcase
		end

		// Mode sequencing.
		case (s.state)
			ST_ACTIVE: begin
				if (s.a_valid && s.a_write && s.a_addr == OFS_MODE &&
						hwdata[2:0] >= REQ_SLEEP && hwdata[2:0] <= REQ_DEEP_POWER_DOWN) begin
					next_s.lp_target = hwdata[2:0];
					next_s.ticks = 15'h0000;
					next_s.state = ST_LP_ENTRY;
				end
			end
			ST_LP_ENTRY: begin
				if (lp_ack) begin
					case (s.lp_target)
						REQ_SLEEP: next_s.state = ST_SLEEP;
						REQ_DEEP_SLEEP: next_s.state = ST_DEEP_SLEEP;
						REQ_POWER_DOWN: begin
							next_s.state = ST_POWER_DOWN;
							next_s.switch_on = 1'b0;
						end
						default: next_s.state = ST_DEEP_POWER_DOWN;
					endcase
				end else if (rtc_tick) begin
					next_s.ticks = s.ticks + 15'h0001;
				end
			end
			ST_SLEEP: begin
				if (wake_src.irq || wake_src.core_wake || wake_src.gpio ||
						wake_src.always_on_system_domain) begin
					next_s.state = ST_ACTIVE;
				end else if (wake_src.bus_wake) begin
					next_s.state = ST_PARTIAL;
				end
			end
			ST_PARTIAL: begin
				if (wake_src.irq) begin
					next_s.state = ST_ACTIVE;
				end else if (wake_src.bus_done) begin
					next_s.state = ST_SLEEP;
				end
			end
			ST_DEEP_SLEEP: begin
				if (wake_src.irq || wake_src.core_wake || wake_src.gpio ||
						wake_src.always_on_system_domain) begin
					next_s.state = ST_ACTIVE;
				end
			end
			ST_POWER_DOWN: next_s.state = s.state;
			ST_DEEP_POWER_DOWN: next_s.state = s.state;
			ST_RST_HOLD: begin
				if (s.hold_cnt == HOLD_CYC - 5'h01) begin
					next_s.ticks = 15'h0000;
					next_s.state = ST_RST_WAIT;
				end else begin
					next_s.hold_cnt = s.hold_cnt + 5'h01;
				end
			end
			ST_RST_WAIT: begin
				if (rst_ack) begin
					next_s.state = ST_CONFIG;
				end else if (rtc_tick) begin
					next_s.ticks = s.ticks + 15'h0001;
				end
			end
			ST_CONFIG: begin
				if (cfg_done) begin
					next_s.wake_rst = 1'b0;
					next_s.state = ST_ACTIVE;
				end
			end
			default: next_s.state = ST_RST_HOLD;
		endcase

		// Timeouts end in a reset of their own; the wait counts only always-on clock ticks.
		if (rtc_tick && s.ticks == TICK_LIMIT && s.state == ST_RST_WAIT) begin
			next_s.cause = CAUSE_RST_TIMEOUT;
			next_s.hold_cnt = 5'h00;
			next_s.state = ST_RST_HOLD;
		end
		if (rtc_tick && s.ticks == TICK_LIMIT && s.state == ST_LP_ENTRY && !lp_ack) begin
			next_s.cause = CAUSE_LP_TIMEOUT;
			next_s.hold_cnt = 5'h00;
			next_s.state = ST_RST_HOLD;
		end

		// Any reset source restarts the sequence; placed last so it wins over a cause clear.
		if (rst_req) begin
			next_s.cause = rst_cause;
			next_s.hold_cnt = 5'h00;
			next_s.state = ST_RST_HOLD;
			if (powered_off) begin
				next_s.wake_rst = 1'b1;
				next_s.switch_on = 1'b1;
			end
		end
	end

	// ========================================================================
	// State register; power-on reset starts the full sequence with every domain in reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ========================================================================
	// Bus answers: zero wait states, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;

	// Reset and handshake outputs.
	assign sys_reset_n = (s.state != ST_RST_HOLD);
	assign wake_reset_n = !(s.wake_rst && s.state == ST_RST_HOLD);
	assign lp_req = (s.state == ST_LP_ENTRY);
	assign cfg_load = (s.state == ST_CONFIG);
	assign switch_on = s.switch_on;
	assign switched_supply_out_en = s.switch_on && s.ctrl[CTRL_SWITCH_OUT_EN];

	// Clock and power enables per mode. The bus clock stays up in partial wake so the
	// bus master can finish, whatever software chose for the bus clock.
	always_comb begin
		pwr_ctl.cpu_halt = !(s.state == ST_ACTIVE || s.state == ST_LP_ENTRY);
		pwr_ctl.core_clk_en = !pwr_ctl.cpu_halt || s.state == ST_CONFIG;
		pwr_ctl.sys_clk_en = !(s.state == ST_DEEP_SLEEP || powered_off);
		pwr_ctl.bus_clk_en = s.state == ST_PARTIAL ||
			(pwr_ctl.sys_clk_en && s.ctrl[CTRL_BUS_CLK_EN]);
		pwr_ctl.core_pwr_en = !powered_off;
		pwr_ctl.core_reg_en = !powered_off;
		pwr_ctl.sys_reg_en = (s.state != ST_POWER_DOWN);
	end

	// Per-block SRAM supply: a block without retention is shut in Deep Sleep, all are lost when powered off.
	for (genvar i = 0; i < SRAM_BLOCKS; i++) begin : g_sram
		assign sram_retain[i] = s.sram_cfg[i] && s.state == ST_DEEP_SLEEP;
		assign sram_pwr_en[i] = !powered_off && !(s.state == ST_DEEP_SLEEP && !s.sram_cfg[i]);
	end

endmodule

`default_nettype wire

// file: design/pmr_pkg.sv
// Shared constants, encodings and carrier types of the power-mode and reset sequencer.
package pmr_pkg;

	// ========================================================================
	// Register map, one aligned word each.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRAM = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_CAUSE = 8'h0c;

	// ========================================================================
	// Control register fields and reset value.
	localparam int CTRL_LVD_EN = 0;
	localparam int CTRL_HVD_EN = 1;
	localparam int CTRL_SCG_LOC_EN = 2;
	localparam int CTRL_SCG_LOL_EN = 3;
	localparam int CTRL_BUS_CLK_EN = 4;
	localparam int CTRL_SWITCH_OUT_EN = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h11;
	localparam logic [31:0] SRAM_RST = 32'hffffffff;

	// ========================================================================
	// Low-power mode request codes written to the mode register.
	localparam logic [2:0] REQ_SLEEP = 3'h1;
	localparam logic [2:0] REQ_DEEP_SLEEP = 3'h2;
	localparam logic [2:0] REQ_POWER_DOWN = 3'h3;
	localparam logic [2:0] REQ_DEEP_POWER_DOWN = 3'h4;

	// ========================================================================
	// Timing.
	localparam int HCLK_PERIOD_NS = 40;
	localparam int SWITCH_WAKE_NS = 1000;
	localparam int SWITCH_WAKE_CYC = (SWITCH_WAKE_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
	localparam int RST_HOLD_CYC = 16;
	localparam int TIMEOUT_TICKS = 8192;

	// ========================================================================
	// Sequencer states, one-hot.
	typedef enum logic [9:0] {
		ST_ACTIVE = 10'h001,
		ST_SLEEP = 10'h002,
		ST_PARTIAL = 10'h004,
		ST_LP_ENTRY = 10'h008,
		ST_DEEP_SLEEP = 10'h010,
		ST_POWER_DOWN = 10'h020,
		ST_DEEP_POWER_DOWN = 10'h040,
		ST_RST_HOLD = 10'h080,
		ST_RST_WAIT = 10'h100,
		ST_CONFIG = 10'h200
	} pmr_state_e;

	// Recorded cause of the latest reset.
	typedef enum logic [4:0] {
		CAUSE_NONE = 5'h00,
		CAUSE_POR = 5'h01,
		CAUSE_PIN = 5'h02,
		CAUSE_LVD = 5'h03,
		CAUSE_HVD = 5'h04,
		CAUSE_WAKEUP = 5'h05,
		CAUSE_DEBUG_PORT = 5'h06,
		CAUSE_RST_TIMEOUT = 5'h07,
		CAUSE_LP_TIMEOUT = 5'h08,
		CAUSE_CLOCK_GEN = 5'h09,
		CAUSE_SOFTWARE = 5'h0a,
		CAUSE_WATCHDOG_A = 5'h0b,
		CAUSE_WATCHDOG_B = 5'h0c,
		CAUSE_LOCKUP = 5'h0d,
		CAUSE_JTAG = 5'h0e,
		CAUSE_SECURITY = 5'h0f
	} pmr_cause_e;

	// ========================================================================
	// Carriers.
	typedef struct packed {
		logic low_voltage_detector;
		logic high_voltage_detector;
		logic clock_loss;
		logic lock_loss;
		logic watchdog_a;
		logic watchdog_b;
		logic software_req;
		logic lockup;
		logic debug_access_port;
		logic jtag_req;
		logic security_violation_reset;
	} pmr_rst_src_s;

	typedef struct packed {
		logic irq;
		logic bus_wake;
		logic bus_done;
		logic core_wake;
		logic gpio;
		logic always_on_system_domain;
	} pmr_wake_src_s;

	typedef struct packed {
		logic cpu_halt;
		logic core_clk_en;
		logic sys_clk_en;
		logic bus_clk_en;
		logic core_pwr_en;
		logic core_reg_en;
		logic sys_reg_en;
	} pmr_pwr_ctl_s;

endpackage

// file: dv/pmr_host.sv
// Host model driving the external reset pin and the power-switch wake pin.
`timescale 1ns/1ps
`default_nettype none
module pmr_host (
	input wire logic hclk,
	output logic ext_reset_n,
	output logic switch_wake_n
);
	// ========================================================================
	// Both pins are pulled up on the board, so an idle host leaves them high.
	initial begin
		ext_reset_n = 1'b1;
		switch_wake_n = 1'b1;
	end

	// Pin reset: a low level held well past the three-stage input filter.
	task automatic pin_reset(input int cyc);
		@(posedge hclk);
		ext_reset_n <= 1'b0;
		repeat (cyc) @(posedge hclk);
		ext_reset_n <= 1'b1;
	endtask

	// Switch wake: the pin stays low for longer than one microsecond.
	task automatic switch_wake(input int ns);
		@(posedge hclk);
		switch_wake_n <= 1'b0;
		#(ns);
		@(posedge hclk);
		switch_wake_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: dv/pmr_sequencer_props.sv
// Concurrent checks on the ports of the power-mode and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module pmr_sequencer_props
	import pmr_pkg::*;
#(
	parameter int SRAM_BLOCKS = 8,
	parameter int TIMEOUT_LIMIT = TIMEOUT_TICKS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ext_reset_n,
	input wire pmr_rst_src_s rst_src,
	input wire logic lp_ack,
	input wire logic rst_ack,
	input wire logic cfg_done,
	input wire logic sys_reset_n,
	input wire logic wake_reset_n,
	input wire logic lp_req,
	input wire logic cfg_load,
	input wire pmr_pwr_ctl_s pwr_ctl,
	input wire logic [SRAM_BLOCKS-1:0] sram_retain
);
	// ========================================================================
	// Sequencing checks; one clock domain, so clocking and disable are shared.
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Core-side sources only count while the core domain is powered.
	src_reset_a: assert property (
		(|rst_src[6:0] && pwr_ctl.core_pwr_en) |=> !sys_reset_n)
		else $error("core reset source ignored");
	pin_reset_a: assert property ($fell(ext_reset_n) |-> ##[1:6] !sys_reset_n)
		else $error("pin reset missed");
	hold_len_a: assert property (
		$fell(sys_reset_n) |-> !sys_reset_n[*8] ##1 !sys_reset_n[*7])
		else $error("reset hold too short");
	cfg_ack_a: assert property ($rose(cfg_load) |-> $past(rst_ack) && sys_reset_n)
		else $error("config without acknowledge");
	cfg_done_a: assert property ($fell(cfg_load) |-> $past(cfg_done) || !sys_reset_n)
		else $error("config left early");
	lp_hold_a: assert property (lp_req && !lp_ack |=> lp_req || !sys_reset_n)
		else $error("low-power request dropped");
	lp_enter_a: assert property (
		$fell(lp_req) && sys_reset_n |-> !pwr_ctl.core_clk_en && $past(lp_ack))
		else $error("low-power entry wrong");
	wake_rst_a: assert property (!wake_reset_n |-> !sys_reset_n)
		else $error("wake reset outside hold");
	retain_a: assert property (|sram_retain |-> pwr_ctl.cpu_halt && !pwr_ctl.core_clk_en)
		else $error("retention while running");

	// Main scenarios.
	cover property ($fell(lp_req) && sys_reset_n);
	cover property ($fell(sys_reset_n));
	cover property (!wake_reset_n);
endmodule

bind pmr_sequencer pmr_sequencer_props #(.SRAM_BLOCKS(SRAM_BLOCKS), .TIMEOUT_LIMIT(TIMEOUT_LIMIT)) chk (
	.hclk, .hresetn, .ext_reset_n, .rst_src, .lp_ack, .rst_ack, .cfg_done, .sys_reset_n,
	.wake_reset_n, .lp_req, .cfg_load, .pwr_ctl, .sram_retain
);
`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench of the power-mode and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb
	import pmr_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic rtc = 1'b0;
	logic hwrite, hreadyout, lp_ack, rst_ack, wrst;
	logic sys_reset_n, wake_reset_n, lp_req, cfg_load, switch_on, sup_en, ext_reset_n, switch_wake_n;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic cfg_done, hresp;
	logic [7:0] sram_retain, sram_pwr_en;
	pmr_rst_src_s rst_src;
	pmr_wake_src_s wake_src;
	pmr_pwr_ctl_s pwr_ctl;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;

	// ========================================================================
	// Clocks; the slow tick runs at 800 ns so shortened timeouts end quickly.
	always #20 hclk = ~hclk;
	always #400 rtc = ~rtc;

	// Latches any wake-domain reset and cuts a hung run short.
	always @(posedge hclk) begin
		if (!wake_reset_n) wrst <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			conclude();
		end
	end

	pmr_host host (.hclk(hclk), .ext_reset_n(ext_reset_n), .switch_wake_n(switch_wake_n));
	pmr_sequencer #(.SRAM_BLOCKS(8), .TIMEOUT_LIMIT(8)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ext_reset_n(ext_reset_n), .switch_wake_n(switch_wake_n), .rtc_clk_32k(rtc), .rst_src(rst_src),
		.wake_src(wake_src), .lp_ack(lp_ack), .rst_ack(rst_ack), .cfg_done(cfg_done), .sys_reset_n(sys_reset_n),
		.wake_reset_n(wake_reset_n), .lp_req(lp_req), .cfg_load(cfg_load), .switch_on(switch_on),
		.switched_supply_out_en(sup_en), .pwr_ctl(pwr_ctl), .sram_pwr_en(sram_pwr_en), .sram_retain(sram_retain)
	);

	// ========================================================================
	// Shared tasks.
	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string n);
		cmp_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, want, seen);
		end
	endtask

	// One single transfer; the address phase is held until ready is seen.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(a, 1'b1, d, x);
	endtask

	// Reads until the masked value matches or the try count runs out.
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want, input string n);
		logic [31:0] x;
		for (int i = 0; i < 400; i++) begin
			xfer(a, 1'b0, 32'h0, x);
			if ((x & m) === want) break;
		end
		chk(x & m, want, n);
	endtask

	task automatic cause_is(input logic [31:0] want, input string n);
		rdc(OFS_MODE, 32'h3ff, 32'h1, n);
		rdc(OFS_CAUSE, 32'h1f, want, n);
	endtask

	task automatic pulse(input pmr_rst_src_s r, input pmr_wake_src_s w);
		rst_src <= r;
		wake_src <= w;
		@(posedge hclk);
		rst_src <= '0;
		wake_src <= '0;
	endtask

	task automatic lp(input logic [2:0] code, input logic [9:0] st);
		wr(OFS_MODE, {29'h0, code});
		@(posedge hclk);
		chk({31'h0, lp_req}, 32'h1, "lp_req");
		lp_ack <= 1'b1;
		@(posedge hclk);
		lp_ack <= 1'b0;
		rdc(OFS_MODE, 32'h3ff, {22'h0, st}, "lp state");
	endtask

	// ========================================================================
	// Scenarios.
	task automatic t_por();
		logic [31:0] x;
		rdc(OFS_MODE, 32'h3ff, 32'h1, "por mode");
		chk({29'h0, hresp, switch_on, sup_en}, 32'h2, "por outputs");
		chk({31'h0, wrst}, 32'h1, "por wake reset");
		rdc(OFS_CAUSE, 32'h1f, 32'h1, "por cause");
		rdc(OFS_CTRL, 32'hffffffff, 32'h11, "ctrl");
		rdc(OFS_SRAM, 32'hffffffff, 32'hff, "sram");
		wr(8'h10, 32'h5);
		rdc(8'h10, 32'hffffffff, 32'h0, "unmapped");
		// A code outside 1..4 must leave the mode alone; read once, a poll would hide a detour.
		wr(OFS_MODE, 32'h5);
		xfer(OFS_MODE, 1'b0, 32'h0, x);
		chk(x & 32'h3ff, 32'h1, "bad mode code");
		wr(OFS_CAUSE, 32'h0);
		pulse(11'h200, '0);
		repeat (4) @(posedge hclk);
		cause_is(32'h0, "hvd off");
	endtask

	task automatic t_sources();
		logic [31:0] code [11] = '{3, 4, 9, 9, 11, 12, 10, 13, 6, 14, 15};
		for (int i = 0; i < 11; i++) begin
			wr(OFS_CTRL, 32'h3f);
			pulse(11'h400 >> i, '0);
			cause_is(code[i], "cause");
		end
		host.pin_reset(8);
		cause_is(32'h2, "pin cause");
	endtask

	task automatic t_sleep();
		logic [5:0] src [4] = '{6'h20, 6'h04, 6'h02, 6'h01};
		// Bus clock off by software, so only the partial wake can raise it.
		wr(OFS_CTRL, 32'h2f);
		lp(3'h1, 10'h002);
		chk({28'h0, pwr_ctl[6:3]}, 32'ha, "sleep clocks");
		pulse('0, 6'h10);
		rdc(OFS_MODE, 32'h3ff, 32'h4, "partial");
		chk({31'h0, pwr_ctl.bus_clk_en}, 32'h1, "bus clock");
		pulse('0, 6'h08);
		rdc(OFS_MODE, 32'h3ff, 32'h2, "resleep");
		pulse('0, 6'h20);
		rdc(OFS_MODE, 32'h3ff, 32'h1, "partial wake");
		wr(OFS_SRAM, 32'ha5);
		for (int i = 0; i < 8; i++) begin
			lp(i < 4 ? 3'h1 : 3'h2, i < 4 ? 10'h002 : 10'h010);
			chk({16'h0, sram_pwr_en, sram_retain}, i < 4 ? 32'hff00 : 32'ha5a5, "sram supply");
			pulse('0, src[i % 4]);
			rdc(OFS_MODE, 32'h3ff, 32'h1, "wake");
		end
	endtask

	task automatic t_off();
		lp(3'h3, 10'h020);
		chk({30'h0, switch_on, sup_en}, 32'h0, "switch off");
		pulse(11'h040, '0);
		repeat (4) @(posedge hclk);
		rdc(OFS_MODE, 32'h3ff, 32'h20, "pdown holds");
		wrst <= 1'b0;
		host.switch_wake(1200);
		cause_is(32'h5, "pdown wake");
		chk({29'h0, wrst, switch_on, sup_en}, 32'h7, "pdown wake reset");
		lp(3'h4, 10'h040);
		chk({21'h0, sram_pwr_en, pwr_ctl[2:0]}, 32'h1, "dpd power");
		rdc(OFS_MODE, 32'h1c00, 32'h1000, "lp target");
		wrst <= 1'b0;
		pulse('0, 6'h01);
		cause_is(32'h5, "dpd wake");
		chk({31'h0, wrst}, 32'h1, "dpd wake reset");
	endtask

	task automatic t_timeouts();
		wr(OFS_MODE, 32'h1);
		cause_is(32'h8, "lp timeout");
		rst_ack <= 1'b0;
		pulse(11'h010, '0);
		rdc(OFS_MODE, 32'h3ff, 32'h100, "reset wait");
		rdc(OFS_CAUSE, 32'h1f, 32'h7, "reset timeout");
		// Hold the configuration load open to see the block wait for it.
		cfg_done <= 1'b0;
		rst_ack <= 1'b1;
		rdc(OFS_MODE, 32'h3ff, 32'h200, "config wait");
		chk({30'h0, cfg_load, pwr_ctl.core_clk_en}, 32'h3, "config load");
		cfg_done <= 1'b1;
		cause_is(32'h7, "timeout end");
	endtask

	// Main sequence: power-on reset, then every scenario in turn.
	initial begin
		haddr = '0;
		hwdata = '0;
		htrans = '0;
		hwrite = 1'b0;
		lp_ack = 1'b0;
		rst_ack = 1'b1;
		cfg_done = 1'b1;
		wrst = 1'b0;
		rst_src = '0;
		wake_src = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_por();
		t_sources();
		t_sleep();
		t_off();
		t_timeouts();
		conclude();
	end
endmodule
`default_nettype wire
